// ---- lct_register_bank.sv ----
// Register bank: cycle timer control, link status and interrupt acknowledge/enable
// What this block does
// - Source select set: external input rising edge bumps count, clears offset.
// - Source select clear: count bumps only when offset wraps past maximum.
// - Offset advances only while timer enable is set, otherwise holds except for the external-edge clear under source select.
// - Read-only transmitter ready flag reads one while transmitter idle.
// - Read-only root flag, refreshed automatically when self-identification ends.
// - Read-only next busy type flag: zero busy A, one busy B.
// - Read-only field holds last acknowledge code for async queue packets.
// - Writing one to a set acknowledge bit clears it.
// - Writing one to clear bit, or zero anywhere, changes nothing.
// - Enable register mirrors acknowledge layout, gating each condition.
// - Link and PHY conditions recorded as individual acknowledge bits.
// - Master and root send cycle start per count; timeout disables until toggled.
// - Bus reset start sets its acknowledge bit and clears identity valid.
`timescale 1ns/1ps
module lct_register_bank
   import lct_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Host byte bus
   input  wire logic [8:0]  host_addr,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   // Link status inputs
   input  wire logic        tx_idle,
   input  wire logic        selfid_done,
   input  wire logic        selfid_root,
   input  wire logic        busy_next_b,
   input  wire logic        async_ack_valid,
   input  wire logic [3:0]  async_ack_code,
   input  wire logic [31:0] link_events,
   input  wire logic        bus_reset_start,
   input  wire logic        external_cycle_input,
   // Outputs to link
   output logic      [31:0] ctrl_out,
   output lct_time_t        cycle_time,
   output logic             cycle_start_req,
   output logic             irq
);

   lct_bank_state_t st_reg;
   lct_bank_state_t st_next;
   lct_host_req_t   req;
   lct_time_t       time_val;
   logic            count_tick;
   logic [31:0]     lane_mask;
   logic [31:0]     wword;
   logic [31:0]     ctrl_view;
   logic [31:0]     diag_view;
   logic [31:0]     timer_view;
   logic [31:0]     rword;
   logic [31:0]     set_bits;
   logic            master_was;
   logic            hit_ctrl;
   logic            hit_ack;
   logic            hit_enable;
   logic            hit_diag;
   logic            hit_timer;
   logic [31:0]     ack_next;

   assign req = '{addr: host_addr, wr: host_wr, rd: host_rd, wdata: host_wdata};

   // ----------------------------------------------------------------
   // Cycle timer
   // ----------------------------------------------------------------
   lct_cycle_timer u_timer (
      .clk                  (clk),
      .reset                (reset),
      .timer_enable         (st_reg.ctrl[LCT_CYCLE_TIMER_ENABLE_BIT]),
      .source_select        (st_reg.ctrl[LCT_CYCLE_SOURCE_SELECT_BIT]),
      .external_cycle_input (external_cycle_input),
      .time_out             (time_val),
      .count_tick           (count_tick)
   );

   // ----------------------------------------------------------------
   // Write lanes and event sets
   // ----------------------------------------------------------------
   assign lane_mask = 32'h000000ff << {req.addr[1:0], 3'b000};
   assign wword     = {4{req.wdata}};
   assign set_bits  = link_events | ({31'h00000000, bus_reset_start} << LCT_BUSRST_BIT);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      hit_ctrl   = 1'b0;
      hit_ack    = 1'b0;
      hit_enable = 1'b0;
      hit_diag   = 1'b0;
      hit_timer  = 1'b0;
      if (req.addr[8:2] == LCT_CTRL_ADDR[8:2]) begin
         hit_ctrl = 1'b1;
      end else if (req.addr[8:2] == LCT_ACK_ADDR[8:2]) begin
         hit_ack = 1'b1;
      end else if (req.addr[8:2] == LCT_ENABLE_ADDR[8:2]) begin
         hit_enable = 1'b1;
      end else if (req.addr[8:2] == LCT_DIAG_ADDR[8:2]) begin
         hit_diag = 1'b1;
      end else if (req.addr[8:2] == LCT_TIMER_ADDR[8:2]) begin
         hit_timer = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge bits
   // ----------------------------------------------------------------
   for (genvar b = 0; b < 32; b++) begin : g_ack_bit
      logic clear_hit;
      assign clear_hit   = req.wr & hit_ack & lane_mask[b] & wword[b];
      assign ack_next[b] = set_bits[b] | (st_reg.ack[b] & ~clear_hit);
   end

   // ----------------------------------------------------------------
   // Read views
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_view = st_reg.ctrl;
      ctrl_view[LCT_TXREADY_BIT]  = tx_idle;
      ctrl_view[LCT_ROOT_BIT]     = st_reg.root;
      ctrl_view[LCT_BUSYTYPE_BIT] = busy_next_b;
      diag_view = '0;
      diag_view[LCT_ACKCODE_LSB +: LCT_ACKCODE_W] = st_reg.ack_code;
      timer_view = time_val;
      if (hit_ctrl) begin
         rword = ctrl_view;
      end else if (hit_ack) begin
         rword = st_reg.ack;
      end else if (hit_enable) begin
         rword = st_reg.enable;
      end else if (hit_diag) begin
         rword = diag_view;
      end else if (hit_timer) begin
         rword = timer_view;
      end else begin
         rword = '0;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next             = st_reg;
      st_next.cycle_start = 1'b0;
      master_was          = st_reg.ctrl[LCT_CYCLE_MASTER_ENABLE_BIT];

      if (req.rd) begin
         st_next.rdata = rword[{req.addr[1:0], 3'b000} +: 8];
      end

      if (req.wr) begin
         if (hit_ctrl) begin
            st_next.ctrl = (st_reg.ctrl & ~(lane_mask & LCT_CTRL_WMASK))
                         | (wword & lane_mask & LCT_CTRL_WMASK);
         end else if (hit_enable) begin
            st_next.enable = (st_reg.enable & ~lane_mask) | (wword & lane_mask);
         end
      end

      st_next.ack = ack_next;

      if (selfid_done) begin
         st_next.root = selfid_root;
         st_next.ctrl[LCT_NODE_IDENTITY_VALID_BIT] = 1'b1;
      end
      if (bus_reset_start) begin
         st_next.ctrl[LCT_NODE_IDENTITY_VALID_BIT] = 1'b0;
      end

      if (async_ack_valid) begin
         st_next.ack_code = async_ack_code;
      end

      if (!master_was) begin
         st_next.master_off = 1'b0;
      end
      if (set_bits[LCT_CYTMOUT_BIT]) begin
         st_next.master_off = 1'b1;
      end
      if (count_tick && master_was && st_reg.root && !st_reg.master_off) begin
         st_next.cycle_start = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg            <= '0;
         st_reg.ctrl       <= LCT_CTRL_RESET;
         st_reg.ack        <= LCT_ACK_RESET;
         st_reg.enable     <= LCT_EN_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign host_rdata      = st_reg.rdata;
   assign ctrl_out        = ctrl_view;
   assign cycle_time      = time_val;
   assign cycle_start_req = st_reg.cycle_start;
   assign irq             = |(st_reg.ack & st_reg.enable);

endmodule // lct_register_bank

// ---- lct_pkg.sv ----
// Package: offsets, fields, reset values and carrier types for the link register bank
package lct_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [8:0] LCT_CTRL_ADDR   = 9'h004;
   localparam logic [8:0] LCT_ACK_ADDR    = 9'h008;
   localparam logic [8:0] LCT_ENABLE_ADDR = 9'h00c;
   localparam logic [8:0] LCT_DIAG_ADDR   = 9'h010;
   localparam logic [8:0] LCT_TIMER_ADDR  = 9'h014;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int LCT_NODE_IDENTITY_VALID_BIT     = 31;
   localparam int LCT_CYCLE_MASTER_ENABLE_BIT    = 11;
   localparam int LCT_CYCLE_SOURCE_SELECT_BIT    = 10;
   localparam int LCT_CYCLE_TIMER_ENABLE_BIT    = 9;
   localparam int LCT_TXREADY_BIT     = 6;
   localparam int LCT_ROOT_BIT        = 5;
   localparam int LCT_BUSYTYPE_BIT    = 4;
   localparam logic [31:0] LCT_CTRL_RESET = 32'h46000002;
   localparam logic [31:0] LCT_CTRL_WMASK = 32'hfe301e02;

   // ----------------------------------------------------------------
   // Acknowledge register fields
   // ----------------------------------------------------------------
   localparam int LCT_BUSRST_BIT      = 13;
   localparam int LCT_CYTMOUT_BIT     = 5;
   localparam logic [31:0] LCT_ACK_RESET  = 32'h00000000;
   localparam logic [31:0] LCT_EN_RESET   = 32'h00000000;

   // ----------------------------------------------------------------
   // Diagnostic field and cycle timer limits
   // ----------------------------------------------------------------
   localparam int LCT_ACKCODE_LSB     = 27;
   localparam int LCT_ACKCODE_W       = 4;
   localparam logic [11:0] LCT_OFFSET_MAX = 12'hbff;
   localparam logic [12:0] LCT_COUNT_MAX  = 13'h1f3f;
   localparam logic [6:0]  LCT_SECOND_MAX = 7'h7f;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [6:0]  second_count;
      logic [12:0] cycle_count;
      logic [11:0] cycle_offset;
   } lct_time_t;

   typedef struct packed {
      lct_time_t time_val;
      logic      external_cycle_input_prev;
      logic      count_tick;
   } lct_timer_state_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] ack;
      logic [31:0] enable;
      logic [3:0]  ack_code;
      logic        root;
      logic        master_off;
      logic        cycle_start;
      logic [7:0]  rdata;
   } lct_bank_state_t;

   typedef struct packed {
      logic [8:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } lct_host_req_t;

endpackage

// ---- lct_cycle_timer.sv ----
// Cycle timer: offset, count and seconds counters with selectable cycle source
`timescale 1ns/1ps
module lct_cycle_timer
   import lct_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Control
   input  wire logic       timer_enable,
   input  wire logic       source_select,
   input  wire logic       external_cycle_input,
   // Status
   output lct_time_t       time_out,
   output logic            count_tick
);

   lct_timer_state_t st_reg;
   lct_timer_state_t st_next;
   logic             ext_rise;
   logic             offset_wrap;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next              = st_reg;
      st_next.external_cycle_input_prev = external_cycle_input;
      st_next.count_tick   = 1'b0;
      ext_rise             = external_cycle_input & ~st_reg.external_cycle_input_prev;
      offset_wrap          = timer_enable && (st_reg.time_val.cycle_offset == LCT_OFFSET_MAX);
      if (timer_enable) begin
         if (offset_wrap) begin
            st_next.time_val.cycle_offset = 12'h000;
         end else begin
            st_next.time_val.cycle_offset = st_reg.time_val.cycle_offset + 12'h001;
         end
      end
      if (source_select && ext_rise) begin
         st_next.time_val.cycle_offset = 12'h000;
         st_next.count_tick            = 1'b1;
      end else if (!source_select && offset_wrap) begin
         st_next.count_tick = 1'b1;
      end
      if (st_next.count_tick) begin
         if (st_reg.time_val.cycle_count == LCT_COUNT_MAX) begin
            st_next.time_val.cycle_count  = 13'h0000;
            st_next.time_val.second_count = st_reg.time_val.second_count + 7'h01;
         end else begin
            st_next.time_val.cycle_count = st_reg.time_val.cycle_count + 13'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign time_out   = st_reg.time_val;
   assign count_tick = st_reg.count_tick;

endmodule // lct_cycle_timer

// ---- lct_properties.sv ----
// Port-level properties of the link register bank
`timescale 1ns/1ps
module lct_properties
   import lct_pkg::*;
(
   // Watched ports
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [8:0]  host_addr,
   input wire logic        host_wr,
   input wire logic        tx_idle,
   input wire logic        busy_next_b,
   input wire logic        selfid_done,
   input wire logic        bus_reset_start,
   input wire logic        external_cycle_input,
   input wire logic [31:0] ctrl_out,
   input wire lct_time_t   cycle_time,
   input wire logic        cycle_start_req
);
   wire [11:0] off = cycle_time.cycle_offset;
   wire [12:0] cnt = cycle_time.cycle_count;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_txready_view: assert property (ctrl_out[6] == tx_idle)
      else $error("tx ready view wrong");
   a_busy_view: assert property (ctrl_out[4] == busy_next_b)
      else $error("busy type view wrong");
   a_offset_hold: assert property (!ctrl_out[9] && !ctrl_out[10] |=> off == $past(off))
      else $error("offset moved while disabled");
   a_offset_step: assert property (ctrl_out[9] && !ctrl_out[10] && off != LCT_OFFSET_MAX
      |=> off == $past(off) + 12'h001)
      else $error("offset did not step");
   a_count_wrap: assert property (ctrl_out[9] && !ctrl_out[10] && off == LCT_OFFSET_MAX
      && cnt != LCT_COUNT_MAX |=> off == 12'h000 && cnt == $past(cnt) + 13'h0001)
      else $error("count missed offset wrap");
   a_count_hold: assert property (!ctrl_out[10] && !(ctrl_out[9] && off == LCT_OFFSET_MAX)
      |=> cnt == $past(cnt))
      else $error("count moved without wrap");
   a_ext_edge: assert property (ctrl_out[10] && external_cycle_input
      && !$past(external_cycle_input) |=> off == 12'h000)
      else $error("offset not cleared on edge");
   a_start_cause: assert property (cycle_start_req
      |-> $past(ctrl_out[11]) && $past(cnt) != $past(cnt, 2))
      else $error("start request without count step");
   a_busrst_node_identity_valid: assert property (bus_reset_start && !selfid_done
      && !(host_wr && host_addr == LCT_CTRL_ADDR + 9'h003) |=> !ctrl_out[31])
      else $error("identity valid kept after bus reset");
endmodule // lct_properties
bind lct_register_bank lct_properties i_lct_properties (.clk, .reset, .host_addr, .host_wr,
   .tx_idle, .busy_next_b, .selfid_done, .bus_reset_start, .external_cycle_input, .ctrl_out,
   .cycle_time, .cycle_start_req);

// ---- lct_host_model.sv ----
// Host byte-bus master model for the link register bank
`timescale 1ns/1ps
module lct_host_model
   import lct_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Host byte bus
   output logic      [8:0] host_addr,
   output logic            host_wr,
   output logic            host_rd,
   output logic      [7:0] host_wdata,
   input  wire logic [7:0] host_rdata
);
   initial begin
      host_addr = 9'h000;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
   end
   task automatic wr8(input logic [8:0] a, input logic [7:0] v);
      @(posedge clk);
      host_addr  <= a;
      host_wdata <= v;
      host_wr    <= 1'b1;
      @(posedge clk);
      host_wr    <= 1'b0;
   endtask
   task automatic rd32(input logic [8:0] a, output logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         host_addr <= a + 9'(i);
         host_rd   <= 1'b1;
         @(posedge clk);
         host_rd   <= 1'b0;
         @(posedge clk);
         #1 v[8*i +: 8] = host_rdata;
      end
   endtask
endmodule // lct_host_model

// ---- lct_register_bank_bench.sv ----
// Self-checking bench for the link register bank
`timescale 1ns/1ps
module lct_register_bank_bench
   import lct_pkg::*;
;
   logic        clk = 1'b0, reset = 1'b1, host_wr, host_rd, cycle_start_req, irq;
   logic [8:0]  host_addr;
   logic [7:0]  host_wdata, host_rdata;
   logic        tx_idle = 0, selfid_done = 0, selfid_root = 0, busy_next_b = 0;
   logic        async_ack_valid = 0, bus_reset_start = 0, external_cycle_input = 0;
   logic [3:0]  async_ack_code = 4'h0;
   logic [31:0] link_events = 32'h0, ctrl_out, d;
   lct_time_t   cycle_time;
   int          fail_count = 0, total_checks = 0, starts = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (cycle_start_req === 1'b1) starts <= starts + 1;
   lct_register_bank i_lct_register_bank (.clk, .reset, .host_addr, .host_wr, .host_rd,
      .host_wdata, .host_rdata, .tx_idle, .selfid_done, .selfid_root, .busy_next_b,
      .async_ack_valid, .async_ack_code, .link_events, .bus_reset_start,
      .external_cycle_input, .ctrl_out, .cycle_time, .cycle_start_req, .irq);
   lct_host_model i_lct_host_model (.clk, .host_addr, .host_wr, .host_rd, .host_wdata,
      .host_rdata);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [8:0] a, input string n, input logic [31:0] e);
      i_lct_host_model.rd32(a, d);
      chk(n, e, d);
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      i_lct_host_model.wr8(a, v);
   endtask
   task automatic events(input logic [31:0] v);
      @(posedge clk);
      link_events <= v;
      @(posedge clk);
      link_events <= 32'h0;
   endtask
   task automatic ext_tick;
      @(posedge clk);
      external_cycle_input <= 1'b1;
      repeat (2) @(posedge clk);
      external_cycle_input <= 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(LCT_CTRL_ADDR, "ctrl", LCT_CTRL_RESET);
      rd(LCT_ACK_ADDR, "ack", LCT_ACK_RESET);
      rd(LCT_ENABLE_ADDR, "enable", LCT_EN_RESET);
      rd(9'h100, "unmapped", 32'h0);
      rd(LCT_TIMER_ADDR, "frozen timer", 32'h0);
      @(posedge clk);
      tx_idle <= 1'b1;
      busy_next_b <= 1'b1;
      wr(LCT_CTRL_ADDR, 8'h00);
      rd(LCT_CTRL_ADDR, "status view", 32'h46000050);
      @(posedge clk);
      selfid_root <= 1'b1;
      selfid_done <= 1'b1;
      @(posedge clk);
      selfid_done <= 1'b0;
      rd(LCT_CTRL_ADDR, "root", 32'hc6000070);
      @(posedge clk);
      bus_reset_start <= 1'b1;
      @(posedge clk);
      bus_reset_start <= 1'b0;
      rd(LCT_CTRL_ADDR, "id cleared", 32'h46000070);
      rd(LCT_ACK_ADDR, "reset flag", 32'h00002000);
      @(posedge clk);
      async_ack_code <= 4'ha;
      async_ack_valid <= 1'b1;
      @(posedge clk);
      async_ack_valid <= 1'b0;
      rd(LCT_DIAG_ADDR, "ack code", 32'h50000000);
      events(32'h00000120);
      rd(LCT_ACK_ADDR, "events", 32'h00002120);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(LCT_ENABLE_ADDR, 8'h20);
      rd(LCT_ENABLE_ADDR, "enable set", 32'h00000020);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(LCT_ACK_ADDR, 8'h80);
      wr(LCT_ACK_ADDR + 9'h001, 8'h00);
      rd(LCT_ACK_ADDR, "no clear", 32'h00002120);
      wr(LCT_ACK_ADDR, 8'h20);
      rd(LCT_ACK_ADDR, "cleared", 32'h00002100);
      chk("irq dropped", 32'h0, {31'h0, irq});
      wr(LCT_CTRL_ADDR + 9'h001, 8'h02);
      repeat (3100) @(posedge clk);
      wr(LCT_CTRL_ADDR + 9'h001, 8'h00);
      i_lct_host_model.rd32(LCT_TIMER_ADDR, d);
      chk("count after wrap", 32'h1, {19'h0, d[24:12]});
      wr(LCT_CTRL_ADDR + 9'h001, 8'h0c);
      ext_tick();
      rd(LCT_TIMER_ADDR, "external tick", 32'h00002000);
      chk("start requests", 32'h1, starts);
      events(32'h00000020);
      ext_tick();
      rd(LCT_TIMER_ADDR, "second tick", 32'h00003000);
      chk("start after timeout", 32'h1, starts);
      wr(LCT_CTRL_ADDR + 9'h001, 8'h04);
      wr(LCT_CTRL_ADDR + 9'h001, 8'h0c);
      ext_tick();
      rd(LCT_TIMER_ADDR, "third tick", 32'h00004000);
      chk("start after rearm", 32'h2, starts);
      stop_test;
   end
endmodule // lct_register_bank_bench
